/* File: rtl/ahc_pkg.sv */
package ahc_pkg;
  // Register offsets on the device register port
  localparam logic [7:0] DATA_RANGE_CONFIG_ADDR = 8'h0e;
  localparam logic [7:0] HIGHPASS_CUTOFF_CONFIG_ADDR = 8'h0f;

  // Field positions in the data range configuration register
  localparam int RANGE_CODE_LSB = 0;
  localparam int HIGHPASS_OUTPUT_SWITCH_BIT = 4;

  // Field positions in the cutoff configuration register
  localparam int CUTOFF_CODE_LSB = 0;
  localparam int TAP_LOWPASS_ENABLE_BIT = 4;
  localparam int TAP_HIGHPASS_BYPASS_BIT = 5;

  // Writable bits of each register; every other bit reads zero
  localparam logic [7:0] DATA_RANGE_CONFIG_MASK = 8'h13;
  localparam logic [7:0] HIGHPASS_CUTOFF_CONFIG_MASK = 8'h33;

  // Reset values
  localparam logic [7:0] DATA_RANGE_CONFIG_RESET = 8'h00;
  localparam logic [7:0] HIGHPASS_CUTOFF_CONFIG_RESET = 8'h00;

  // Full-scale range codes
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;

  // Output sample rate codes, fastest first: 800 400 200 100 50 12.5 6.25 1.56 Hz
  localparam logic [2:0] RATE_800HZ = 3'h0;
  localparam logic [2:0] RATE_400HZ = 3'h1;
  localparam logic [2:0] RATE_200HZ = 3'h2;
  localparam logic [2:0] RATE_100HZ = 3'h3;
  localparam logic [2:0] RATE_50HZ = 3'h4;
  localparam logic [2:0] RATE_12HZ5 = 3'h5;

  // Widest corner of the high-pass filter; the corner is this figure halved shift times
  localparam int CORNER_BASE_HZ = 16;

  // Oversampling modes
  typedef enum logic [1:0] {
    AHC_OS_NORMAL,
    AHC_OS_LOW_NOISE_LOW_POWER,
    AHC_OS_HIGH_RES,
    AHC_OS_LOW_POWER
  } ahc_os_mode_t;
endpackage : ahc_pkg

/* File: rtl/ahc_config.sv */
// Functional notes
// [RL1] Data range register holds range code and high-pass switch at bit 4.
// [RL2] High-pass switch at zero delivers unfiltered samples; it resets to zero.
// [RL3] Range code bits 1:0 select 2, 4 or 8 g; code 11 reserved.
// [RL4] After reset the range is 2 g and high-pass output is off.
// [RL5] Switch set puts high-pass result into the output data registers.
// [RL6] Cutoff register holds a two-bit cutoff code resetting to 00.
// [RL7] Corner follows code, rate and mode; each code step halves it.
// [RL8] High-resolution mode keeps corner 16, 8, 4, 2 Hz regardless of rate.
// [RL9] Bit 5 set sends unfiltered data to pulse detection; resets to zero.
// [RL10] Bit 4 of cutoff register enables pulse-path low-pass; resets to zero.
// [RL11] Unused bits of both registers read zero and ignore writes.
`timescale 1ns/1ps
module ahc_config #(
  parameter int SAMPLE_WIDTH = 12
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [2:0] output_sample_rate_in,
  input wire ahc_pkg::ahc_os_mode_t os_mode_in,
  input wire logic sample_valid_in,
  input wire logic signed [SAMPLE_WIDTH-1:0] raw_sample_in,
  input wire logic signed [SAMPLE_WIDTH-1:0] hp_sample_in,
  output logic data_valid_out,
  output logic signed [SAMPLE_WIDTH-1:0] data_sample_out,
  output logic signed [SAMPLE_WIDTH-1:0] pulse_sample_out,
  output logic tap_lowpass_enable_out,
  output logic highpass_output_switch_out,
  output logic [1:0] full_scale_range_code_out,
  output logic [1:0] cutoff_code_out,
  output logic [3:0] corner_shift_out
);
  import ahc_pkg::*;

  logic [7:0] data_range_config_q;
  logic [7:0] highpass_cutoff_config_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic highpass_output_switch;
  logic tap_highpass_bypass;
  logic [1:0] full_scale_range_code;
  logic [1:0] cutoff_code;
  logic [3:0] corner_shift_d;
  logic [3:0] corner_shift_q;
  logic [1:0] range_shift;
  logic signed [SAMPLE_WIDTH-1:0] out_sel;
  logic signed [SAMPLE_WIDTH-1:0] data_q;
  logic signed [SAMPLE_WIDTH-1:0] pulse_q;
  logic valid_q;

  // Field views of the stored registers
  assign highpass_output_switch = data_range_config_q[HIGHPASS_OUTPUT_SWITCH_BIT];
  assign full_scale_range_code = data_range_config_q[RANGE_CODE_LSB +: 2];
  assign cutoff_code = highpass_cutoff_config_q[CUTOFF_CODE_LSB +: 2];
  assign tap_highpass_bypass = highpass_cutoff_config_q[TAP_HIGHPASS_BYPASS_BIT];

  // Data range register; masking keeps unused bits at zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      data_range_config_q <= DATA_RANGE_CONFIG_RESET; // RL4
    end else if (reg_wr_in && reg_addr_in == DATA_RANGE_CONFIG_ADDR) begin
      data_range_config_q <= reg_wdata_in & DATA_RANGE_CONFIG_MASK; // RL1 RL11
    end
  end

  // Cutoff register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      highpass_cutoff_config_q <= HIGHPASS_CUTOFF_CONFIG_RESET; // RL6
    end else if (reg_wr_in && reg_addr_in == HIGHPASS_CUTOFF_CONFIG_ADDR) begin
      highpass_cutoff_config_q <= reg_wdata_in & HIGHPASS_CUTOFF_CONFIG_MASK; // RL11
    end
  end

  // Read decode; other addresses belong to other blocks and read zero here
  always_comb begin
    if (reg_addr_in == DATA_RANGE_CONFIG_ADDR) begin
      rdata_d = data_range_config_q;
    end else if (reg_addr_in == HIGHPASS_CUTOFF_CONFIG_ADDR) begin
      rdata_d = highpass_cutoff_config_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  // Read data is captured on the read strobe and held until the next one
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_q <= rdata_d;
    end
  end

  // Extra halvings of the corner due to rate and mode, code excluded
  function automatic logic [3:0] rate_shift(input logic [2:0] rate, input ahc_os_mode_t mode);
    logic [3:0] s;
    s = 4'h0;
    case (mode)
      AHC_OS_HIGH_RES: s = 4'h0; // RL8
      AHC_OS_LOW_POWER: begin
        // Corner halves with every rate step down to 50 Hz, then halves twice more for the slowest band
        if (rate >= RATE_12HZ5) s = 4'h6;
        else s = {1'b0, rate};
      end
      AHC_OS_LOW_NOISE_LOW_POWER: begin
        if (rate >= RATE_12HZ5) s = 4'h5;
        else if (rate <= RATE_400HZ) s = 4'h0;
        else s = {1'b0, rate} - 4'h1;
      end
      default: begin
        if (rate >= RATE_50HZ) s = 4'h3;
        else if (rate <= RATE_400HZ) s = 4'h0;
        else s = {1'b0, rate} - 4'h1;
      end
    endcase
    return s;
  endfunction : rate_shift

  // Corner shift: corner = 16 Hz / 2**shift, largest shift 9 gives 0.031 Hz
  assign corner_shift_d = rate_shift(output_sample_rate_in, os_mode_in)
    + {2'b00, cutoff_code}; // RL7

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      corner_shift_q <= 4'h0;
    end else begin
      corner_shift_q <= corner_shift_d; // RL7
    end
  end

  // Range scaling: each wider range halves the counts per g; code 11 behaves as 8 g
  always_comb begin
    if (full_scale_range_code == RANGE_2G) begin
      range_shift = 2'h0;
    end else if (full_scale_range_code == RANGE_4G) begin
      range_shift = 2'h1;
    end else begin
      range_shift = 2'h2;
    end
  end

  // Output source selection ahead of scaling
  assign out_sel = highpass_output_switch ? hp_sample_in : raw_sample_in; // RL2 RL5

  // Output data, updated only with a new sample
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      data_q <= '0;
    end else if (sample_valid_in) begin
      data_q <= out_sel >>> range_shift; // RL1 RL3
    end
  end

  // Pulse path source, kept at full resolution for the detector
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pulse_q <= '0;
    end else if (sample_valid_in) begin
      pulse_q <= tap_highpass_bypass ? raw_sample_in : hp_sample_in; // RL9
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= sample_valid_in;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign data_valid_out = valid_q;
  assign data_sample_out = data_q;
  assign pulse_sample_out = pulse_q;
  assign tap_lowpass_enable_out = highpass_cutoff_config_q[TAP_LOWPASS_ENABLE_BIT]; // RL10
  assign highpass_output_switch_out = highpass_output_switch;
  assign full_scale_range_code_out = full_scale_range_code;
  assign cutoff_code_out = cutoff_code;
  assign corner_shift_out = corner_shift_q;

  // Checks
  property p_hp_out_selects_hp;
    @(posedge mclk_in) disable iff (reset_in)
      sample_valid_in && highpass_output_switch && range_shift == 2'h0
        |=> data_sample_out == $past(hp_sample_in);
  endproperty
  a_hp_out_selects_hp: assert property (p_hp_out_selects_hp) else $error("no hp data"); // RL5

  property p_raw_when_off;
    @(posedge mclk_in) disable iff (reset_in)
      sample_valid_in && !highpass_output_switch && range_shift == 2'h0
        |=> data_sample_out == $past(raw_sample_in);
  endproperty
  a_raw_when_off: assert property (p_raw_when_off) else $error("raw data not selected"); // RL2

  property p_reset_defaults;
    @(posedge mclk_in) reset_in |=> full_scale_range_code_out == RANGE_2G
      && !highpass_output_switch_out && cutoff_code_out == 2'h0 && !tap_lowpass_enable_out;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state"); // RL4

  property p_range_scale_4g;
    @(posedge mclk_in) disable iff (reset_in)
      sample_valid_in && full_scale_range_code == RANGE_4G
        |=> data_sample_out == ($past(out_sel) >>> 1);
  endproperty
  a_range_scale_4g: assert property (p_range_scale_4g) else $error("4 g scaling wrong"); // RL3

  property p_hires_corner;
    @(posedge mclk_in) disable iff (reset_in)
      os_mode_in == AHC_OS_HIGH_RES |=> corner_shift_out == {2'b00, $past(cutoff_code)};
  endproperty
  a_hires_corner: assert property (p_hires_corner) else $error("hires corner wrong"); // RL8

  property p_lowest_corner;
    @(posedge mclk_in) disable iff (reset_in)
      os_mode_in == AHC_OS_LOW_POWER && output_sample_rate_in == 3'h7 && cutoff_code == 2'h3
        |=> corner_shift_out == 4'h9;
  endproperty
  a_lowest_corner: assert property (p_lowest_corner) else $error("lowest corner wrong"); // RL7

  property p_pulse_bypass;
    @(posedge mclk_in) disable iff (reset_in)
      sample_valid_in && tap_highpass_bypass |=> pulse_sample_out == $past(raw_sample_in);
  endproperty
  a_pulse_bypass: assert property (p_pulse_bypass) else $error("pulse bypass wrong"); // RL9

  property p_unused_zero;
    @(posedge mclk_in) disable iff (reset_in)
      reg_wr_in |=> (data_range_config_q & ~DATA_RANGE_CONFIG_MASK) == 8'h00
        && (highpass_cutoff_config_q & ~HIGHPASS_CUTOFF_CONFIG_MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit stored"); // RL11

  property p_lowpass_write;
    @(posedge mclk_in) disable iff (reset_in)
      reg_wr_in && reg_addr_in == HIGHPASS_CUTOFF_CONFIG_ADDR
        |=> tap_lowpass_enable_out == $past(reg_wdata_in[TAP_LOWPASS_ENABLE_BIT])
        && cutoff_code_out == $past(reg_wdata_in[1:0]);
  endproperty
  a_lowpass_write: assert property (p_lowpass_write) else $error("cutoff write lost"); // RL6 RL10

  property p_range_write;
    @(posedge mclk_in) disable iff (reset_in)
      reg_wr_in && reg_addr_in == DATA_RANGE_CONFIG_ADDR
        |=> highpass_output_switch_out == $past(reg_wdata_in[HIGHPASS_OUTPUT_SWITCH_BIT]);
  endproperty
  a_range_write: assert property (p_range_write) else $error("range write lost"); // RL1

  property p_range_scale_8g;
    @(posedge mclk_in) disable iff (reset_in)
      sample_valid_in && full_scale_range_code == RANGE_8G
        |=> data_sample_out == ($past(out_sel) >>> 2);
  endproperty
  a_range_scale_8g: assert property (p_range_scale_8g) else $error("8 g scaling wrong"); // RL3

  property p_pulse_highpass;
    @(posedge mclk_in) disable iff (reset_in)
      sample_valid_in && !tap_highpass_bypass |=> pulse_sample_out == $past(hp_sample_in);
  endproperty
  a_pulse_highpass: assert property (p_pulse_highpass) else $error("pulse hp wrong"); // RL9

  property p_valid_follows;
    @(posedge mclk_in) disable iff (reset_in)
      1'b1 |=> data_valid_out == $past(sample_valid_in);
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("valid not one cycle"); // RL5

  property p_read_range;
    @(posedge mclk_in) disable iff (reset_in)
      reg_rd_in && reg_addr_in == DATA_RANGE_CONFIG_ADDR
        |=> reg_rdata_out == $past(data_range_config_q);
  endproperty
  a_read_range: assert property (p_read_range) else $error("range readback wrong"); // RL1

  property p_read_cutoff;
    @(posedge mclk_in) disable iff (reset_in)
      reg_rd_in && reg_addr_in == HIGHPASS_CUTOFF_CONFIG_ADDR
        |=> reg_rdata_out == $past(highpass_cutoff_config_q);
  endproperty
  a_read_cutoff: assert property (p_read_cutoff) else $error("cutoff readback wrong"); // RL6

  property p_range_hold;
    @(posedge mclk_in) disable iff (reset_in)
      !(reg_wr_in && reg_addr_in == DATA_RANGE_CONFIG_ADDR)
        |=> $stable(data_range_config_q);
  endproperty
  a_range_hold: assert property (p_range_hold) else $error("range reg changed"); // RL1

  property p_cutoff_hold;
    @(posedge mclk_in) disable iff (reset_in)
      !(reg_wr_in && reg_addr_in == HIGHPASS_CUTOFF_CONFIG_ADDR)
        |=> $stable(highpass_cutoff_config_q);
  endproperty
  a_cutoff_hold: assert property (p_cutoff_hold) else $error("cutoff reg changed"); // RL6

  property p_corner_bound;
    @(posedge mclk_in) disable iff (reset_in)
      corner_shift_out <= 4'h9;
  endproperty
  a_corner_bound: assert property (p_corner_bound) else $error("corner below floor"); // RL7
endmodule : ahc_config

/* File: bench/test_accel_range_and_highpass_config.sv */
`timescale 1ns/1ps
module test_accel_range_and_highpass_config;
  import ahc_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [2:0] output_sample_rate_in = 3'h0;
  ahc_os_mode_t os_mode_in = AHC_OS_NORMAL;
  logic sample_valid_in = 1'b0;
  logic signed [11:0] raw_sample_in = 12'sh000;
  logic signed [11:0] hp_sample_in = 12'sh000;
  logic data_valid_out, tap_lowpass_enable_out, highpass_output_switch_out;
  logic signed [11:0] data_sample_out, pulse_sample_out;
  logic [1:0] full_scale_range_code_out, cutoff_code_out;
  logic [3:0] corner_shift_out;
  int bad_count = 0;
  int tests_run = 0;
  int cycle_count = 0;
  // Generous ceiling; the full run needs well under a thousand cycles
  localparam int CYCLE_LIMIT = 5000;
  // Corner shift at code 00 per mode (normal, low-noise, high-res, low-power) and rate
  int base_tab[4][8] = '{'{0,0,1,2,3,3,3,3}, '{0,0,1,2,3,5,5,5}, '{0,0,0,0,0,0,0,0},
                         '{0,1,2,3,4,6,6,6}};
  logic [7:0] rd_q;

  ahc_config uut (.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .output_sample_rate_in(output_sample_rate_in),
    .os_mode_in(os_mode_in), .sample_valid_in(sample_valid_in), .raw_sample_in(raw_sample_in),
    .hp_sample_in(hp_sample_in), .data_valid_out(data_valid_out),
    .data_sample_out(data_sample_out), .pulse_sample_out(pulse_sample_out),
    .tap_lowpass_enable_out(tap_lowpass_enable_out),
    .highpass_output_switch_out(highpass_output_switch_out),
    .full_scale_range_code_out(full_scale_range_code_out), .cutoff_code_out(cutoff_code_out),
    .corner_shift_out(corner_shift_out));

  // Free-running 50 MHz clock
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  // Hang guard
  always @(posedge mclk_in) begin
    cycle_count = cycle_count + 1;
    if (cycle_count == CYCLE_LIMIT) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic signed [15:0] seen,
                       input logic signed [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Strobes last one cycle; the edge after launch takes them
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
    #1 rd_q = reg_rdata_out;
  endtask : reg_read

  task automatic test_reset_values();
    reg_read(8'h0e);
    check("range reg", 16'(rd_q), 16'h0000);
    check("switch", 16'(highpass_output_switch_out), 16'h0000);
    reg_read(8'h0f);
    check("cutoff reg", 16'(rd_q), 16'h0000);
    check("lowpass en", 16'(tap_lowpass_enable_out), 16'h0000);
  endtask : test_reset_values

  task automatic test_unused_bits();
    reg_write(8'h0e, 8'hfe); // Range code 10 (8 g) with every unused bit set
    reg_write(8'h0f, 8'hff);
    reg_write(8'h10, 8'h00); // Unmapped write must not disturb either register
    reg_read(8'h0e);
    check("range reg", 16'(rd_q), 16'h0012);
    reg_read(8'h0f);
    check("cutoff reg", 16'(rd_q), 16'h0033);
    reg_read(8'h0d);
    check("unmapped", 16'(rd_q), 16'h0000);
    check("lowpass en", 16'(tap_lowpass_enable_out), 16'h0001);
    reg_write(8'h0f, 8'h00);
    @(posedge mclk_in);
    #1 check("lowpass en", 16'(tap_lowpass_enable_out), 16'h0000);
  endtask : test_unused_bits

  // Every range, switch and bypass setting, with a negative high-pass word
  task automatic test_sample_path();
    int e;
    for (int rc = 0; rc < 3; rc++) begin
      for (int sw = 0; sw < 2; sw++) begin
        for (int byp = 0; byp < 2; byp++) begin
          reg_write(8'h0e, 8'((sw << 4) | rc));
          reg_write(8'h0f, 8'(byp << 5));
          @(posedge mclk_in);
          sample_valid_in <= 1'b1;
          raw_sample_in <= 12'sd100;
          hp_sample_in <= -12'sd40;
          @(posedge mclk_in);
          sample_valid_in <= 1'b0;
          #1 check("switch", 16'(highpass_output_switch_out), 16'(sw));
          check("range out", 16'(full_scale_range_code_out), 16'(rc));
          check("valid", 16'(data_valid_out), 16'h0001);
          e = (sw != 0) ? (-40 >>> rc) : (100 >>> rc);
          check("data", 16'(data_sample_out), 16'(e));
          check("pulse", 16'(pulse_sample_out), (byp != 0) ? 16'sd100 : -16'sd40);
          @(posedge mclk_in);
          #1 check("valid", 16'(data_valid_out), 16'h0000);
        end
      end
    end
  endtask : test_sample_path

  // Corner for every code, mode and rate
  task automatic test_corner();
    for (int c = 0; c < 4; c++) begin
      reg_write(8'h0f, 8'(c));
      for (int m = 0; m < 4; m++) begin
        for (int r = 0; r < 8; r++) begin
          @(posedge mclk_in);
          output_sample_rate_in <= 3'(r);
          os_mode_in <= ahc_os_mode_t'(m);
          @(posedge mclk_in);
          @(posedge mclk_in);
          #1 check("cutoff out", 16'(cutoff_code_out), 16'(c));
          check("corner", 16'(corner_shift_out), 16'(base_tab[m][r] + c));
        end
      end
    end
  endtask : test_corner

  // Reset in mid-run must undo non-default settings
  task automatic test_mid_reset();
    reg_write(8'h0e, 8'h11);
    reg_write(8'h0f, 8'h31);
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    #1 check("switch", 16'(highpass_output_switch_out), 16'h0000);
    check("range out", 16'(full_scale_range_code_out), 16'h0000);
    check("cutoff out", 16'(cutoff_code_out), 16'h0000);
    check("lowpass en", 16'(tap_lowpass_enable_out), 16'h0000);
    reg_read(8'h0e);
    check("range reg", 16'(rd_q), 16'h0000);
  endtask : test_mid_reset

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    test_reset_values();
    test_unused_bits();
    test_sample_path();
    test_corner();
    test_mid_reset();
    report_and_stop();
  end
endmodule : test_accel_range_and_highpass_config
